// *** logic/xp_pkg.sv ***
// Constants and carrier types for the extra interrupt, nibble port and power-control block
// Operation
// - Interrupt control register sits at C0 hex and is bit-addressable.
// - Bits 7..0: prio3, enable3, flag3, type3, prio2, enable2, flag2, type2.
// - Set priority bit puts that interrupt in the high level.
// - An extra interrupt requests service only while its enable bit is set.
// - Type bit set selects falling edge; clear selects low level.
// - Edge mode: falling edge sets flag; servicing clears it automatically.
// - Interrupt 2 vectors to 33 hex, polling position 6.
// - Interrupt 3 vectors to 3B hex, polling position 7, lowest.
// - Legacy sources keep vectors 03..2B hex and polling positions 0..5.
// - Four-bit bit-addressable port at D8 hex, behaving like port 1.
// - Port pins 3 and 2 double as active-low interrupt inputs 3, 2.
// - Auxiliary register bit 0 at 8E hex stops the address-latch strobe.
// - Strobe still runs during external accesses, suppressed again afterwards.
// - Gain fuse programmed to 0 halves oscillator amplifier gain.
// - Power-off flag bit 4 at 87 hex set at power-on, kept by reset.
// - Two general-purpose flag bits, freely read and written, no hardware function.
// - Writing 1 to the power-down bit enters power-down mode.
// - Writing 1 to the idle bit enters idle mode.
// - Idle stops processor clock only; any interrupt or reset ends it.
// - Reset clears registers to 00 except power-off flag; port latches to ones.
package xp_pkg;

  localparam logic [7:0] XP_ADDR_PWR  = 8'h87;
  localparam logic [7:0] XP_ADDR_AUX  = 8'h8E;
  localparam logic [7:0] XP_ADDR_XIRQ = 8'hC0;
  localparam logic [7:0] XP_ADDR_PORT = 8'hD8;

  localparam int unsigned XP_XI_TYPE2 = 0;
  localparam int unsigned XP_XI_FLAG2 = 1;
  localparam int unsigned XP_XI_EN2   = 2;
  localparam int unsigned XP_XI_PRIO2 = 3;
  localparam int unsigned XP_XI_TYPE3 = 4;
  localparam int unsigned XP_XI_FLAG3 = 5;
  localparam int unsigned XP_XI_EN3   = 6;
  localparam int unsigned XP_XI_PRIO3 = 7;

  localparam int unsigned XP_PC_IDLE = 0;
  localparam int unsigned XP_PC_DOWN = 1;
  localparam int unsigned XP_PC_UF0  = 2;
  localparam int unsigned XP_PC_UF1  = 3;
  localparam int unsigned XP_PC_POF  = 4;
  localparam int unsigned XP_AUX_STROBE_OFF = 0;

  localparam logic [7:0] XP_RST_SFR  = 8'h00;
  localparam logic [3:0] XP_RST_PORT = 4'hF;
  localparam logic       XP_POF_POR  = 1'b1;

  // Core clocks per machine cycle
  localparam logic [3:0] XP_MC_CLKS = 4'hC;

  localparam logic [2:0] XP_SRC_IRQ2 = 3'h6;
  localparam logic [2:0] XP_SRC_IRQ3 = 3'h7;
  localparam logic [7:0] XP_VECTOR [8] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33, 8'h3B};

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic       bit_val;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xp_sfr_req_s;

endpackage

// *** logic/xp_sync2.sv ***
// Two-flop synchroniser for pin inputs
`default_nettype none
module xp_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  // Idle-high reset, matching released pins
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '1;
      dout   <= '1;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end

endmodule
`default_nettype wire

// *** logic/xp_irq_chan.sv ***
// One extra external interrupt channel: sampling, edge/level detect and flag
`default_nettype none
module xp_irq_chan (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Sampling
  input  wire logic sample_tick,
  input  wire logic pin,
  input  wire logic edge_sel,
  // Software and service
  input  wire logic sw_we,
  input  wire logic sw_val,
  input  wire logic serviced,
  // Status
  output logic      flag
);

  logic prev;
  logic next_prev;
  logic next_flag;

  always_comb begin
    next_prev = prev;
    next_flag = flag;
    if (sw_we) begin
      next_flag = sw_val;
    end
    if (serviced && edge_sel) begin
      next_flag = 1'b0;
    end
    if (sample_tick) begin
      next_prev = pin;
      if (edge_sel) begin
        // Placed last so a detected edge beats any clear
        if (prev && !pin) begin
          next_flag = 1'b1;
        end
      end else begin
        next_flag = ~pin;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= 1'b1;
      flag <= 1'b0;
    end else begin
      prev <= next_prev;
      flag <= next_flag;
    end
  end

  a_edge_sets_flag: assert property (
    @(posedge clk) disable iff (rst)
    sample_tick && edge_sel && prev && !pin |=> flag)
    else $error("falling edge did not set flag");

  a_level_follows: assert property (
    @(posedge clk) disable iff (rst)
    sample_tick && !edge_sel |=> flag == !$past(pin))
    else $error("level flag does not follow pin");

  a_service_clears: assert property (
    @(posedge clk) disable iff (rst)
    serviced && edge_sel && !sample_tick && !sw_we |=> !flag)
    else $error("service did not clear edge flag");

endmodule
`default_nettype wire

// *** logic/xp_top.sv ***
// Extra interrupts, nibble port, strobe suppression and power control
`default_nettype none
module xp_top (
  // Clock and resets
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     por,
  // Register access from core
  input  wire xp_pkg::xp_sfr_req_s      sfr_req,
  output logic [7:0]                    sfr_rdata,
  output logic                          sfr_hit,
  // Interrupt service from core
  input  wire logic                     svc_ack,
  input  wire logic [2:0]               svc_src,
  input  wire logic [5:0]               legacy_req,
  input  wire logic [5:0]               legacy_high,
  // Vector selection to core
  output logic                          vec_valid,
  output logic [7:0]                    vec_addr,
  output logic [2:0]                    vec_src,
  output logic                          vec_high,
  // Nibble port pins
  input  wire logic [3:0]               port_pin_in,
  output logic [3:0]                    port_pin_out,
  output logic [3:0]                    port_pin_oe_n,
  // Address-latch strobe
  input  wire logic                     ext_access,
  input  wire logic                     ale_core,
  output logic                          ale_out,
  // Oscillator gain
  input  wire logic                     osc_gain_fuse,
  output logic                          osc_half_gain,
  // Power state
  output logic                          idle_mode,
  output logic                          power_down,
  output logic                          cpu_clk_run
);

  // Power-on also resets everything else
  logic rst_any;
  assign rst_any = rst | por;

  // Register state
  logic [7:0] ext_irq_control_ctl;
  logic [3:0] port_latch;
  logic       strobe_off;
  logic       user_flag_0;
  logic       user_flag_1;
  logic       power_off_flag;
  logic [3:0] mc_cnt;
  logic       sample_tick;
  logic [7:0] next_ext_irq_control_ctl;
  logic [3:0] next_port_latch;
  logic       next_strobe_off;
  logic       next_user_flag_0;
  logic       next_user_flag_1;
  logic       next_power_off_flag;
  logic       next_idle_mode;
  logic       next_power_down;
  logic [3:0] next_mc_cnt;
  logic       next_sample_tick;

  // Outputs
  logic [7:0] next_sfr_rdata;
  logic       next_sfr_hit;
  logic       next_vec_valid;
  logic [7:0] next_vec_addr;
  logic [2:0] next_vec_src;
  logic       next_vec_high;
  logic       next_ale_out;

  // Synchronised pins and fuse
  logic [4:0] sync_in;
  logic [3:0] pin_s;
  logic       fuse_s;

  // Channel status
  logic       irq2_flag;
  logic       irq3_flag;
  logic [7:0] ext_irq_control_wr;
  logic       ext_irq_control_we;
  logic [7:0] ext_irq_control_rd;
  logic [7:0] port_wr;
  logic [7:0] pend;
  logic [7:0] high;

  xp_sync2 #(
    .WIDTH (5)
  ) u_sync (
    .clk  (clk),
    .rst  (rst_any),
    .din  ({osc_gain_fuse, port_pin_in}),
    .dout (sync_in)
  );

  assign pin_s  = sync_in[3:0];
  assign fuse_s = sync_in[4];

  // Write detection: byte writes by address, bit writes by bit address
  function automatic logic wr_hit(input logic [7:0] base, input logic bitable, input xp_pkg::xp_sfr_req_s r);
    wr_hit = (r.wr && r.addr == base) || (bitable && r.bit_wr && r.addr[7:3] == base[7:3]);
  endfunction

  function automatic logic [7:0] wr_val(input logic [7:0] old, input xp_pkg::xp_sfr_req_s r);
    logic [7:0] v;
    v = old;
    if (r.wr) begin
      v = r.wdata;
    end else begin
      v[r.addr[2:0]] = r.bit_val;
    end
    wr_val = v;
  endfunction

  always_comb begin
    ext_irq_control_rd                        = ext_irq_control_ctl;
    ext_irq_control_rd[xp_pkg::XP_XI_FLAG2]   = irq2_flag;
    ext_irq_control_rd[xp_pkg::XP_XI_FLAG3]   = irq3_flag;
  end

  assign ext_irq_control_we = wr_hit(xp_pkg::XP_ADDR_XIRQ, 1'b1, sfr_req);
  assign ext_irq_control_wr = wr_val(ext_irq_control_rd, sfr_req);
  assign port_wr  = wr_val({4'h0, port_latch}, sfr_req);

  // pins 3 and 2 feed interrupts 3 and 2
  xp_irq_chan u_irq2 (
    .clk         (clk),
    .rst         (rst_any),
    .sample_tick (sample_tick),
    .pin         (pin_s[2]),
    .edge_sel    (ext_irq_control_ctl[xp_pkg::XP_XI_TYPE2]),
    .sw_we       (ext_irq_control_we),
    .sw_val      (ext_irq_control_wr[xp_pkg::XP_XI_FLAG2]),
    .serviced    (svc_ack && svc_src == xp_pkg::XP_SRC_IRQ2),
    .flag        (irq2_flag)
  );

  xp_irq_chan u_irq3 (
    .clk         (clk),
    .rst         (rst_any),
    .sample_tick (sample_tick),
    .pin         (pin_s[3]),
    .edge_sel    (ext_irq_control_ctl[xp_pkg::XP_XI_TYPE3]),
    .sw_we       (ext_irq_control_we),
    .sw_val      (ext_irq_control_wr[xp_pkg::XP_XI_FLAG3]),
    .serviced    (svc_ack && svc_src == xp_pkg::XP_SRC_IRQ3),
    .flag        (irq3_flag)
  );

  // Register writes and power state
  always_comb begin
    next_ext_irq_control_ctl      = ext_irq_control_ctl;
    next_port_latch     = port_latch;
    next_strobe_off     = strobe_off;
    next_user_flag_0    = user_flag_0;
    next_user_flag_1    = user_flag_1;
    next_power_off_flag = power_off_flag;
    next_idle_mode      = idle_mode;
    next_power_down     = power_down;
    next_sample_tick    = 1'b0;
    next_mc_cnt         = mc_cnt + 4'h1;
    if (mc_cnt == xp_pkg::XP_MC_CLKS - 4'h1) begin
      next_mc_cnt      = 4'h0;
      next_sample_tick = 1'b1;
    end
    if (ext_irq_control_we) begin
      next_ext_irq_control_ctl = ext_irq_control_wr;
    end
    if (wr_hit(xp_pkg::XP_ADDR_PORT, 1'b1, sfr_req)) begin
      next_port_latch = port_wr[3:0];
    end
    if (wr_hit(xp_pkg::XP_ADDR_AUX, 1'b0, sfr_req)) begin
      next_strobe_off = sfr_req.wdata[xp_pkg::XP_AUX_STROBE_OFF];
    end
    if (wr_hit(xp_pkg::XP_ADDR_PWR, 1'b0, sfr_req)) begin
      next_user_flag_0    = sfr_req.wdata[xp_pkg::XP_PC_UF0];
      next_user_flag_1    = sfr_req.wdata[xp_pkg::XP_PC_UF1];
      next_power_off_flag = sfr_req.wdata[xp_pkg::XP_PC_POF];
      next_idle_mode      = idle_mode | sfr_req.wdata[xp_pkg::XP_PC_IDLE];
      next_power_down     = power_down | sfr_req.wdata[xp_pkg::XP_PC_DOWN];
    end
    if (vec_valid) begin
      next_idle_mode = 1'b0;
    end
  end

  // pending and level per polling position
  always_comb begin
    pend       = {irq3_flag & ext_irq_control_ctl[xp_pkg::XP_XI_EN3], irq2_flag & ext_irq_control_ctl[xp_pkg::XP_XI_EN2], legacy_req};
    high       = {ext_irq_control_ctl[xp_pkg::XP_XI_PRIO3], ext_irq_control_ctl[xp_pkg::XP_XI_PRIO2], legacy_high};
  end

  // fixed vectors, lowest position wins within level
  always_comb begin
    next_vec_valid = |pend;
    next_vec_high  = |(pend & high);
    next_vec_src   = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pend[i] && (high[i] || !next_vec_high)) begin
        next_vec_src = i[2:0];
      end
    end
    next_vec_addr = xp_pkg::XP_VECTOR[next_vec_src];
  end

  always_comb begin
    next_ale_out = ale_core & (~strobe_off | ext_access);
  end

  // Register reads; port reads the pins, as the standard port does
  always_comb begin
    next_sfr_hit   = sfr_req.rd;
    next_sfr_rdata = xp_pkg::XP_RST_SFR;
    unique case (sfr_req.addr)
      xp_pkg::XP_ADDR_XIRQ: next_sfr_rdata = ext_irq_control_rd;
      xp_pkg::XP_ADDR_PORT: next_sfr_rdata = {4'h0, pin_s};
      xp_pkg::XP_ADDR_AUX:  next_sfr_rdata[xp_pkg::XP_AUX_STROBE_OFF] = strobe_off;
      xp_pkg::XP_ADDR_PWR: begin
        next_sfr_rdata[xp_pkg::XP_PC_POF]  = power_off_flag;
        next_sfr_rdata[xp_pkg::XP_PC_UF1]  = user_flag_1;
        next_sfr_rdata[xp_pkg::XP_PC_UF0]  = user_flag_0;
        next_sfr_rdata[xp_pkg::XP_PC_DOWN] = power_down;
        next_sfr_rdata[xp_pkg::XP_PC_IDLE] = idle_mode;
      end
      default:              next_sfr_hit = 1'b0;
    endcase
    if (!sfr_req.rd) begin
      next_sfr_rdata = xp_pkg::XP_RST_SFR;
    end
  end

  // power-on sets the power-off flag; reset leaves it, register writes change it
  always_ff @(posedge clk) begin
    if (por) begin
      power_off_flag <= xp_pkg::XP_POF_POR;
    end else begin
      power_off_flag <= next_power_off_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_any) begin
      ext_irq_control_ctl     <= xp_pkg::XP_RST_SFR;
      port_latch    <= xp_pkg::XP_RST_PORT;
      port_pin_oe_n <= xp_pkg::XP_RST_PORT;
      port_pin_out  <= 4'h0;
      strobe_off    <= 1'b0;
      user_flag_0   <= 1'b0;
      user_flag_1   <= 1'b0;
      idle_mode     <= 1'b0;
      power_down    <= 1'b0;
      cpu_clk_run   <= 1'b1;
      mc_cnt        <= 4'h0;
      sample_tick   <= 1'b0;
      sfr_rdata     <= xp_pkg::XP_RST_SFR;
      sfr_hit       <= 1'b0;
      vec_valid     <= 1'b0;
      vec_addr      <= xp_pkg::XP_RST_SFR;
      vec_src       <= 3'h0;
      vec_high      <= 1'b0;
      ale_out       <= 1'b0;
      osc_half_gain <= 1'b0;
    end else begin
      ext_irq_control_ctl     <= next_ext_irq_control_ctl;
      port_latch    <= next_port_latch;
      // Quasi-bidirectional: pull low on a zero latch, release on one
      port_pin_oe_n <= next_port_latch;
      port_pin_out  <= 4'h0;
      strobe_off    <= next_strobe_off;
      user_flag_0   <= next_user_flag_0;
      user_flag_1   <= next_user_flag_1;
      idle_mode     <= next_idle_mode;
      power_down    <= next_power_down;
      cpu_clk_run   <= ~(next_idle_mode | next_power_down);
      mc_cnt        <= next_mc_cnt;
      sample_tick   <= next_sample_tick;
      sfr_rdata     <= next_sfr_rdata;
      sfr_hit       <= next_sfr_hit;
      vec_valid     <= next_vec_valid;
      vec_addr      <= next_vec_addr;
      vec_src       <= next_vec_src;
      vec_high      <= next_vec_high;
      ale_out       <= next_ale_out;
      osc_half_gain <= ~fuse_s;
    end
  end

  a_irq2_needs_en: assert property (
    @(posedge clk) disable iff (rst_any)
    vec_valid && vec_src == xp_pkg::XP_SRC_IRQ2 |-> $past(ext_irq_control_ctl[xp_pkg::XP_XI_EN2]) && $past(irq2_flag))
    else $error("interrupt 2 selected while disabled");

  a_irq_vectors: assert property (
    @(posedge clk) disable iff (rst_any)
    vec_valid |-> vec_addr == {2'b00, vec_src, 3'b011})
    else $error("vector address does not match source");

  a_high_first: assert property (
    @(posedge clk) disable iff (rst_any)
    $past(pend[7] && high[7]) && !$past(rst_any) |-> vec_high && vec_src != xp_pkg::XP_SRC_IRQ3 || vec_src == xp_pkg::XP_SRC_IRQ3)
    else $error("high level interrupt not preferred");

  a_irq3_lowest: assert property (
    @(posedge clk) disable iff (rst_any)
    vec_valid && vec_src == xp_pkg::XP_SRC_IRQ3 |-> $past(pend & high) == 8'h80 || $past(pend) == 8'h80 ||
      ($past(pend & high) == 8'h00 && $past(pend[6:0]) == 7'h00))
    else $error("interrupt 3 beat a higher polling position");

  a_strobe_off: assert property (
    @(posedge clk) disable iff (rst_any)
    strobe_off && !ext_access && !$past(ext_access) ##1 !ext_access |-> !ale_out)
    else $error("strobe toggled while suppressed");

  a_strobe_ext: assert property (
    @(posedge clk) disable iff (rst_any)
    ext_access |=> ale_out == $past(ale_core))
    else $error("strobe blocked during external access");

  a_pof_kept: assert property (
    @(posedge clk) disable iff (por)
    rst |=> power_off_flag == $past(power_off_flag))
    else $error("reset changed power-off flag");

  a_pd_sticks: assert property (
    @(posedge clk) disable iff (rst_any)
    power_down |=> power_down && !cpu_clk_run)
    else $error("power-down left without reset");

  a_idle_wake: assert property (
    @(posedge clk) disable iff (rst_any)
    idle_mode && vec_valid |=> !idle_mode)
    else $error("idle not ended by interrupt");

  a_reset_port: assert property (
    @(posedge clk)
    rst |=> port_latch == xp_pkg::XP_RST_PORT && ext_irq_control_ctl == xp_pkg::XP_RST_SFR && !idle_mode)
    else $error("reset values wrong");

  a_gain_half: assert property (
    @(posedge clk) disable iff (rst_any)
    !osc_gain_fuse [*4] |=> osc_half_gain)
    else $error("gain not halved for programmed fuse");

endmodule
`default_nettype wire

// *** dv/xp_core_model.sv ***
// Processor core model: register accesses and interrupt service
`default_nettype none
module xp_core_model (
  // Clock
  input  wire logic                 clk,
  // Register bus
  output var  xp_pkg::xp_sfr_req_s sfr_req,
  input  wire logic [7:0]           sfr_rdata,
  input  wire logic                 sfr_hit,
  // Interrupt service
  output var  logic                 svc_ack,
  output var  logic [2:0]           svc_src
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sfr_req = '0;
    svc_ack = 1'b0;
    svc_src = 3'h0;
  end

  // Each access is one strobe cycle, released just after the taking edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    #1;
    // Fields in order: wr, rd, bit_wr, bit_val, addr, wdata
    sfr_req = {4'b1000, a, dat};
    @(posedge clk);
    #1;
    sfr_req = '0;
  endtask

  task automatic reg_bit(input logic [7:0] a, input logic val);
    @(posedge clk);
    #1;
    sfr_req = {3'b001, val, a, 8'h00};
    @(posedge clk);
    #1;
    sfr_req = '0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] dat, output logic hit);
    @(posedge clk);
    #1;
    sfr_req = {4'b0100, a, 8'h00};
    @(posedge clk);
    #1;
    dat = sfr_rdata;
    hit = sfr_hit;
    sfr_req = '0;
  endtask

  task automatic service(input logic [2:0] s);
    @(posedge clk);
    #1;
    svc_ack = 1'b1;
    svc_src = s;
    @(posedge clk);
    #1;
    svc_ack = 1'b0;
    svc_src = 3'h0;
  endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the extra interrupt, nibble port and power block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                por = 1'b1;
  xp_pkg::xp_sfr_req_s sfr_req;
  logic [7:0]          sfr_rdata;
  logic                sfr_hit;
  logic                svc_ack;
  logic [2:0]          svc_src;
  logic [5:0]          legacy_req = 6'h00;
  logic [5:0]          legacy_high = 6'h00;
  logic                vec_valid;
  logic [7:0]          vec_addr;
  logic [2:0]          vec_src;
  logic                vec_high;
  logic [3:0]          pin_drv = 4'hF;
  logic [3:0]          port_pin_out;
  logic [3:0]          port_pin_oe_n;
  logic                ext_access = 1'b0;
  logic                ale_core = 1'b0;
  logic                ale_out;
  logic                osc_gain_fuse = 1'b1;
  logic                osc_half_gain;
  logic                idle_mode;
  logic                power_down;
  logic                cpu_clk_run;
  logic [7:0]          d;
  logic [7:0]          m;
  logic [3:0]          w;
  logic                h;
  logic                v;
  int                  i;
  int                  miscompares = 0;
  int                  samples_checked = 0;
  int                  seed = 9602;
  // Open-drain pins with pull-up: a low enable pulls the wire low
  wire logic [3:0]     port_pin_in = pin_drv & port_pin_oe_n;

  xp_top DUT (.clk(clk), .rst(rst), .por(por), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .svc_ack(svc_ack), .svc_src(svc_src), .legacy_req(legacy_req), .legacy_high(legacy_high),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_src(vec_src), .vec_high(vec_high),
    .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
    .ext_access(ext_access), .ale_core(ale_core), .ale_out(ale_out), .osc_gain_fuse(osc_gain_fuse),
    .osc_half_gain(osc_half_gain), .idle_mode(idle_mode), .power_down(power_down), .cpu_clk_run(cpu_clk_run));

  xp_core_model core (.clk(clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .svc_ack(svc_ack), .svc_src(svc_src));

  always #4 clk = ~clk;

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic b1(input string n, input logic e, input logic g);
    chk(n, {7'h0, e}, {7'h0, g});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic eh);
    core.reg_rd(a, d, h);
    chk("sfr_rdata", e, d);
    b1("sfr_hit", eh, h);
  endtask

  task automatic vchk(input logic [2:0] s, input logic hi);
    chk("vec_src", {5'h0, s}, {5'h0, vec_src});
    chk("vec_addr", {2'h0, s, 3'h3}, vec_addr);
    b1("vec_high", hi, vec_high);
  endtask

  task automatic wait_vec(input logic e);
    int n;
    n = 0;
    while (vec_valid !== e && n < 40) begin
      cyc(1);
      n++;
    end
    b1("vec_valid", e, vec_valid);
  endtask

  // High level first, then lowest polling position
  function automatic logic [3:0] win(input logic [7:0] rq, input logic [7:0] hi);
    for (int l = 1; l >= 0; l--) begin
      for (int k = 0; k < 8; k++) begin
        if (rq[k] && hi[k] == l[0]) begin
          return {1'b1, 3'(k)};
        end
      end
    end
    return 4'h0;
  endfunction

  initial begin
    #400000;
    miscompares++;
    end_sim();
  end

  initial begin
    cyc(3);
    rst = 1'b0;
    por = 1'b0;
    chk("oe_n", 8'h0F, {4'h0, port_pin_oe_n});
    rchk(8'h87, 8'h10, 1'b1);
    rchk(8'h8E, 8'h00, 1'b1);
    rchk(8'hC0, 8'h00, 1'b1);
    rchk(8'h90, 8'h00, 1'b0);
    core.reg_wr(8'h87, 8'h1C);
    rchk(8'h87, 8'h1C, 1'b1);
    rst = 1'b1;
    cyc(1);
    rst = 1'b0;
    rchk(8'h87, 8'h10, 1'b1);
    core.reg_wr(8'h87, 8'h0C);
    rchk(8'h87, 8'h0C, 1'b1);
    for (int k = 0; k < 40; k++) begin
      if (k == 20) core.reg_wr(8'h8E, 8'h01);
      ale_core = 1'($random(seed));
      ext_access = 1'($random(seed));
      cyc(1);
      b1("ale_out", ale_core & (k < 20 || ext_access), ale_out);
    end
    ale_core = 1'b0;
    rchk(8'h8E, 8'h01, 1'b1);
    osc_gain_fuse = 1'b0;
    cyc(5);
    b1("half_gain", 1'b1, osc_half_gain);
    osc_gain_fuse = 1'b1;
    cyc(5);
    b1("half_gain", 1'b0, osc_half_gain);
    m = 8'h00;
    for (int k = 0; k < 32; k++) begin
      i = k % 8;
      if (i % 4 != 1) begin
        v = 1'($random(seed));
        m[i] = v;
        core.reg_bit(8'hC0 + 8'(i), v);
        rchk(8'hC0, m, 1'b1);
      end
    end
    m = 8'h0F;
    for (int k = 0; k < 12; k++) begin
      i = $random(seed) & 3;
      v = 1'($random(seed));
      m[i] = v;
      core.reg_bit(8'hD8 + 8'(i), v);
      cyc(3);
      chk("oe_n", m, {4'h0, port_pin_oe_n});
      chk("pin_out", 8'h00, {4'h0, port_pin_out});
      rchk(8'hD8, m, 1'b1);
    end
    core.reg_wr(8'hD8, 8'hFA);
    cyc(3);
    rchk(8'hD8, 8'h0A, 1'b1);
    core.reg_wr(8'hD8, 8'h0F);
    pin_drv = 4'($random(seed));
    cyc(4);
    rchk(8'hD8, {4'h0, pin_drv}, 1'b1);
    pin_drv = 4'hF;
    core.reg_wr(8'hC0, 8'h00);
    for (int k = 0; k < 20; k++) begin
      legacy_req = (k == 0) ? 6'h00 : 6'($random(seed));
      legacy_high = 6'($random(seed));
      cyc(3);
      w = win({2'b00, legacy_req}, {2'b00, legacy_high});
      b1("vec_valid", w[3], vec_valid);
      if (w[3]) vchk(w[2:0], legacy_high[w[2:0]]);
    end
    legacy_req = 6'h00;
    legacy_high = 6'h00;
    // Edge mode on input 3
    core.reg_wr(8'hC0, 8'h50);
    pin_drv[3] = 1'b0;
    wait_vec(1'b1);
    vchk(3'h7, 1'b0);
    rchk(8'hC0, 8'h70, 1'b1);
    pin_drv[3] = 1'b1;
    core.service(3'h7);
    cyc(3);
    b1("vec_valid", 1'b0, vec_valid);
    rchk(8'hC0, 8'h50, 1'b1);
    core.reg_wr(8'hC0, 8'h10);
    pin_drv[3] = 1'b0;
    cyc(30);
    b1("vec_valid", 1'b0, vec_valid);
    rchk(8'hC0, 8'h30, 1'b1);
    pin_drv[3] = 1'b1;
    // Level mode on input 2, high level beats a low legacy source
    core.reg_wr(8'hC0, 8'h0C);
    legacy_req = 6'h01;
    pin_drv[2] = 1'b0;
    cyc(30);
    vchk(3'h6, 1'b1);
    rchk(8'hC0, 8'h0E, 1'b1);
    pin_drv[2] = 1'b1;
    cyc(30);
    vchk(3'h0, 1'b0);
    legacy_req = 6'h00;
    core.reg_wr(8'h87, 8'h0D);
    cyc(1);
    b1("idle", 1'b1, idle_mode);
    b1("cpu_clk_run", 1'b0, cpu_clk_run);
    legacy_req = 6'h10;
    cyc(4);
    b1("idle", 1'b0, idle_mode);
    b1("cpu_clk_run", 1'b1, cpu_clk_run);
    legacy_req = 6'h00;
    core.reg_wr(8'h87, 8'h0E);
    cyc(1);
    b1("power_down", 1'b1, power_down);
    b1("cpu_clk_run", 1'b0, cpu_clk_run);
    core.reg_wr(8'h87, 8'h0C);
    cyc(1);
    b1("power_down", 1'b1, power_down);
    rst = 1'b1;
    cyc(1);
    rst = 1'b0;
    b1("power_down", 1'b0, power_down);
    rchk(8'h87, 8'h00, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
